// ===== pkg/ds3_pmdl_tx_regs.vh
// Register map, field positions, frame constants and timing counts for the
// path maintenance data link transmitter.
// Assumes inclusion by bare name from every design file that needs it.
// Behaviour
// - Size bit: 0 gives 76 bytes, 1 gives 82
// - Disabled engine drives every data link bit one
// - Enabling starts continuous 0x7E flag octets immediately
// - Reset clears enable; data link bits all ones
// - Rising edge of start bit 3 launches message
// - Busy bit 2 high for whole transmission
// - Interrupt enable bit 1 gates completion interrupt
// - Status bit 0 reports completion, cleared on read
// - Four header octets precede the buffered payload
// - Header octets fixed: 7E, 3C, 01, 03
// - Sixteen-bit check value follows payload immediately
// - Check polynomial x16 + x12 + x5 + 1
// - One closing flag octet ends the frame
// - Frame serialized bitwise into data link slots
// - Data link slots are three bits per M-frame
// - Resend same message every second while enabled
// - Flags sent continuously whenever idle and enabled
// - Repeats and idle flags run until enable cleared
// - Payload only: zero after five consecutive ones
`ifndef DS3_PMDL_TX_REGS_VH
`define DS3_PMDL_TX_REGS_VH

`define DL_CFG_ADDR 8'h33
`define DL_STAT_ADDR 8'h34
`define DL_BUF_FIRST 8'h86
`define DL_BUF_LAST 8'hdd
`define DL_BUF_DEPTH 88

`define DL_CFG_ENABLE 0
`define DL_CFG_SIZE 1
`define DL_CFG_AUTO 3
`define DL_ST_START 3
`define DL_ST_BUSY 2
`define DL_ST_IEN 1
`define DL_ST_IRQ 0

`define DL_LEN_SHORT 7'h4c
`define DL_LEN_LONG 7'h52

`define DL_FLAG 8'h7e
`define DL_SAPI 8'h3c
`define DL_TEI 8'h01
`define DL_CTRL 8'h03
`define DL_HDR_LAST 7'h03

`define DL_CRC_INIT 16'hffff
`define DL_CRC_POLY 16'h8408
`define DL_STUFF_RUN 3'h5

`define DL_RETX_MS 1000
`define DL_CLK_KHZ 50000
// One second at 50 MHz, sized to the interval counter so no bits are cut.
`define DL_RETX_CYCLES 26'h2faf080

`endif

// ===== rtl/fcs16_serial.v
// Bit-serial frame check accumulator, reflected form, one data bit per shift.
// Assumes the caller pulses init before the first covered bit.
`include "ds3_pmdl_tx_regs.vh"

module fcs16_serial
(
   input wire mclk,
   input wire rst_n,
   input wire init,
   input wire shiftEn,
   input wire dataBit,
   output wire [15:0] crcNext
);

   reg [15:0] crc;
   wire feedback;

   assign feedback = crc[0] ^ dataBit;
   assign crcNext = {1'b0, crc[15:1]} ^ (feedback ? `DL_CRC_POLY : 16'h0000);

   always @(posedge mclk)
   begin
      if (!rst_n || init)
         crc <= `DL_CRC_INIT;
      else if (shiftEn)
         crc <= crcNext;
   end

endmodule

// ===== rtl/interval_timer.v
// One-shot interval counter: a restart pulse arms it, and one period later it
// gives a single tick. Halt drops it at once.
// Assumes restart and halt come from logic on the same clock.
module interval_timer
#(
   parameter [25:0] PERIOD = 26'h00003e8
)
(
   input wire mclk,
   input wire rst_n,
   input wire restart,
   input wire halt,
   output reg tick
);

   reg running;
   reg [25:0] count;

   always @(posedge mclk)
   begin
      if (!rst_n || halt)
      begin
         running <= 1'b0;
         count <= 26'h0000000;
         tick <= 1'b0;
      end
      else
      begin
         tick <= 1'b0;
         if (restart)
         begin
            running <= 1'b1;
            count <= 26'h0000000;
         end
         else if (running)
         begin
            if (count == PERIOD - 26'h0000001)
            begin
               tick <= 1'b1;
               running <= 1'b0;
            end
            else
               count <= count + 26'h0000001;
         end
      end
   end

endmodule

// ===== rtl/ds3_pmdl_lapd_transmitter.v
// Transmit message engine for the DS3 path maintenance data link: register
// bank, message buffer, frame builder, bit stuffer and data link serializer.
// Assumes the transmit framer pulses dlSlot once for each data link bit
// position it inserts, on mclk, and takes dlBit in the cycle after the pulse.
`include "ds3_pmdl_tx_regs.vh"

module ds3_pmdl_lapd_transmitter
#(
   parameter [25:0] RETX_CYCLES = `DL_RETX_CYCLES
)
(
   input wire mclk,
   input wire rst_n,
   input wire [7:0] busAddr,
   input wire [7:0] busWrData,
   input wire busWr,
   input wire busRd,
   output reg [7:0] busRdData,
   input wire dlSlot,
   output reg dlBit,
   output reg doneIrq
);

   localparam [2:0] PH_FLAG = 3'h0;
   localparam [2:0] PH_HDR = 3'h1;
   localparam [2:0] PH_PAY = 3'h2;
   localparam [2:0] PH_FCS = 3'h3;
   localparam [2:0] PH_CLOSE = 3'h4;

   // Configuration and status bits.
   reg txEnable;
   reg sizeLong;
   reg autoRetx;
   reg startBit;
   reg irqEnable;
   reg irqStatus;
   reg busy;
   reg startPend;

   // Message buffer, one byte per location.
   reg [7:0] msgBuf [0:`DL_BUF_DEPTH-1];

   // Serializer state.
   reg [2:0] phase;
   reg [7:0] shifter;
   reg [2:0] bitIdx;
   reg [6:0] octIdx;
   reg [2:0] onesCnt;
   reg stuffPend;
   reg [7:0] fcsLow;

   wire cfgHit;
   wire statHit;
   wire bufHit;
   wire [7:0] bufOffset;
   wire startEdge;
   wire startAccept;
   wire dataSlot;
   wire octetEnd;
   wire launch;
   wire doneNow;
   wire crcShift;
   wire retxTick;
   wire [15:0] crcNext;
   wire [6:0] msgLen;
   wire [6:0] octNext;
   wire [7:0] payNext;
   reg [7:0] hdrNext;

   assign cfgHit = (busAddr == `DL_CFG_ADDR);
   assign statHit = (busAddr == `DL_STAT_ADDR);
   assign bufHit = (busAddr >= `DL_BUF_FIRST) && (busAddr <= `DL_BUF_LAST);
   assign bufOffset = busAddr - `DL_BUF_FIRST;

   assign msgLen = sizeLong ? `DL_LEN_LONG : `DL_LEN_SHORT;

   assign startEdge = busWr && statHit && busWrData[`DL_ST_START] && !startBit;
   // A start while disabled or already busy is dropped; the host owns ordering.
   assign startAccept = startEdge && txEnable && !busy;

   assign dataSlot = dlSlot && txEnable && !stuffPend;
   assign octetEnd = dataSlot && (bitIdx == 3'h7);
   assign launch = octetEnd && (phase == PH_FLAG) && startPend;
   assign doneNow = octetEnd && (phase == PH_CLOSE);

   assign crcShift = dataSlot && ((phase == PH_HDR) || (phase == PH_PAY));

   assign octNext = octIdx + 7'h01;
   assign payNext = msgBuf[octNext];

   always @*
   begin
      hdrNext = `DL_FLAG;
      case (octNext[1:0])
         2'h1: hdrNext = `DL_SAPI;
         2'h2: hdrNext = `DL_TEI;
         2'h3: hdrNext = `DL_CTRL;
         default: hdrNext = `DL_FLAG;
      endcase
   end

   fcs16_serial crcUnit
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .init(launch),
      .shiftEn(crcShift),
      .dataBit(shifter[0]),
      .crcNext(crcNext)
   );

   interval_timer #(.PERIOD(RETX_CYCLES)) retxTimer
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .restart(doneNow),
      .halt(!txEnable),
      .tick(retxTick)
   );

   // Host writes to configuration and status control bits.
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         txEnable <= 1'b0;
         sizeLong <= 1'b0;
         autoRetx <= 1'b0;
         startBit <= 1'b0;
         irqEnable <= 1'b0;
      end
      else if (busWr)
      begin
         if (cfgHit)
         begin
            txEnable <= busWrData[`DL_CFG_ENABLE];
            sizeLong <= busWrData[`DL_CFG_SIZE];
            autoRetx <= busWrData[`DL_CFG_AUTO];
         end
         if (statHit)
         begin
            startBit <= busWrData[`DL_ST_START];
            irqEnable <= busWrData[`DL_ST_IEN];
         end
      end
   end

   // The buffer has no reset; the host loads it before any start.
   always @(posedge mclk)
   begin
      if (busWr && bufHit)
         msgBuf[bufOffset[6:0]] <= busWrData;
   end

   // Start request and busy tracking.
   always @(posedge mclk)
   begin
      if (!rst_n || !txEnable)
      begin
         busy <= 1'b0;
         startPend <= 1'b0;
      end
      else
      begin
         if (startAccept || retxTick)
            busy <= 1'b1;
         else if (doneNow)
            busy <= 1'b0;
         if (startAccept || retxTick)
            startPend <= 1'b1;
         else if (launch)
            startPend <= 1'b0;
      end
   end

   // Completion status and the interrupt it drives.
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         irqStatus <= 1'b0;
         doneIrq <= 1'b0;
      end
      else
      begin
         if (doneNow)
            irqStatus <= 1'b1;
         else if (busRd && statHit)
            irqStatus <= 1'b0;
         doneIrq <= irqStatus && irqEnable;
      end
   end

   // Read data is registered and appears the cycle after busRd.
   always @(posedge mclk)
   begin
      if (!rst_n)
         busRdData <= 8'h00;
      else if (busRd)
      begin
         if (cfgHit)
            busRdData <= {4'h0, autoRetx, 1'b0, sizeLong, txEnable};
         else if (statHit)
            busRdData <= {4'h0, startBit, busy, irqEnable, irqStatus};
         else if (bufHit)
            busRdData <= msgBuf[bufOffset[6:0]];
         else
            busRdData <= 8'h00;
      end
   end

   // Serializer: one bit leaves on each data link slot.
   always @(posedge mclk)
   begin
      if (!rst_n || !txEnable)
      begin
         phase <= PH_FLAG;
         shifter <= `DL_FLAG;
         bitIdx <= 3'h0;
         octIdx <= 7'h00;
         onesCnt <= 3'h0;
         stuffPend <= 1'b0;
         fcsLow <= 8'h00;
         dlBit <= 1'b1;
      end
      else if (dlSlot)
      begin
         if (stuffPend)
         begin
            dlBit <= 1'b0;
            stuffPend <= 1'b0;
            onesCnt <= 3'h0;
         end
         else
         begin
            dlBit <= shifter[0];
            if ((phase == PH_PAY) && shifter[0])
            begin
               if (onesCnt == `DL_STUFF_RUN - 3'h1)
               begin
                  stuffPend <= 1'b1;
                  onesCnt <= 3'h0;
               end
               else
                  onesCnt <= onesCnt + 3'h1;
            end
            else
               onesCnt <= 3'h0;
            if (bitIdx != 3'h7)
            begin
               shifter <= {1'b0, shifter[7:1]};
               bitIdx <= bitIdx + 3'h1;
            end
            else
            begin
               bitIdx <= 3'h0;
               case (phase)
                  PH_FLAG:
                  begin
                     shifter <= `DL_FLAG;
                     octIdx <= 7'h00;
                     if (startPend)
                        phase <= PH_HDR;
                  end
                  PH_HDR:
                  begin
                     if (octIdx == `DL_HDR_LAST)
                     begin
                        phase <= PH_PAY;
                        octIdx <= 7'h00;
                        shifter <= msgBuf[0];
                     end
                     else
                     begin
                        octIdx <= octNext;
                        shifter <= hdrNext;
                     end
                  end
                  PH_PAY:
                  begin
                     if (octNext == msgLen)
                     begin
                        phase <= PH_FCS;
                        octIdx <= 7'h00;
                        shifter <= ~crcNext[15:8];
                        fcsLow <= ~crcNext[7:0];
                     end
                     else
                     begin
                        octIdx <= octNext;
                        shifter <= payNext;
                     end
                  end
                  PH_FCS:
                  begin
                     if (octIdx == 7'h00)
                     begin
                        octIdx <= 7'h01;
                        shifter <= fcsLow;
                     end
                     else
                     begin
                        phase <= PH_CLOSE;
                        octIdx <= 7'h00;
                        shifter <= `DL_FLAG;
                     end
                  end
                  PH_CLOSE:
                  begin
                     phase <= PH_FLAG;
                     shifter <= `DL_FLAG;
                  end
                  default:
                  begin
                     phase <= PH_FLAG;
                     shifter <= `DL_FLAG;
                  end
               endcase
            end
         end
      end
   end

endmodule

// ===== verification/ds3_pmdl_lapd_transmitter_chk.sv
// Checker for the data link transmitter, bound to its top-level ports.
// Assumes registered read data and a data link bit that follows each slot.
module ds3_pmdl_lapd_transmitter_chk
(
   input wire mclk,
   input wire rst_n,
   input wire [7:0] busAddr,
   input wire [7:0] busWrData,
   input wire busWr,
   input wire busRd,
   input wire [7:0] busRdData,
   input wire dlSlot,
   input wire dlBit,
   input wire doneIrq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cfg;
   logic start;
   logic ien;
   logic newEn;
   wire cfgWr = busWr && busAddr == 8'h33;
   wire stWr = busWr && busAddr == 8'h34;
   // Shadow copies of the written control bits, so reads can be judged.
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         cfg <= 4'h0;
         start <= 1'b0;
         ien <= 1'b0;
         newEn <= 1'b0;
      end
      else
      begin
         if (cfgWr)
            cfg <= busWrData[3:0] & 4'hb;
         if (stWr)
         begin
            start <= busWrData[3];
            ien <= busWrData[1];
         end
         if (cfgWr && busWrData[0] && !cfg[0])
            newEn <= 1'b1;
         else if (dlSlot)
            newEn <= 1'b0;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_reset_idle: assert property ($rose(rst_n) |-> dlBit && !doneIrq && busRdData == 8'h00)
      else $error("outputs not idle after reset");
   a_disabled_ones: assert property (!cfg[0] && !$past(cfg[0]) |-> dlBit)
      else $error("data link bit low while disabled");
   a_first_flag: assert property (newEn && dlSlot |=> !dlBit)
      else $error("first bit after enabling is not a flag start");
   a_irq_gated: assert property (doneIrq |-> $past(ien))
      else $error("interrupt raised while disabled");
   a_cfg_read: assert property (busRd && !busWr && busAddr == 8'h33 |=> busRdData == {4'h0, cfg})
      else $error("configuration readback wrong");
   a_stat_read: assert property (busRd && !busWr && busAddr == 8'h34
      |=> busRdData[7:3] == {4'h0, start} && busRdData[1] == ien)
      else $error("status readback wrong");
   a_irq_read_clear: assert property (doneIrq && busRd && busAddr == 8'h34 |-> ##2 !doneIrq)
      else $error("interrupt not cleared by status read");
   a_dl_on_slot: assert property ($changed(dlBit) |-> $past(dlSlot) || !cfg[0] || !$past(cfg[0]))
      else $error("data link bit changed without a slot");
endmodule

bind ds3_pmdl_lapd_transmitter ds3_pmdl_lapd_transmitter_chk chk_u (.mclk(mclk), .rst_n(rst_n),
   .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr), .busRd(busRd), .busRdData(busRdData),
   .dlSlot(dlSlot), .dlBit(dlBit), .doneIrq(doneIrq));

// ===== verification/dl_framer_model.sv
// Model of the transmit framer that asks for data link bits.
// Assumes the engine answers on dlBit in the cycle after each slot pulse.
module dl_framer_model
(
   input wire mclk,
   input wire rst_n,
   input wire fast,
   output logic dlSlot,
   input wire dlBit,
   output logic bitValid,
   output logic bitOut
);
   timeunit 1ns;
   timeprecision 1ps;
   int pos = 0;
   int gap = 0;
   logic took = 1'b0;
   initial dlSlot = 1'b0;
   initial bitValid = 1'b0;
   initial bitOut = 1'b1;
   always @(posedge mclk)
   begin
      took <= dlSlot;
      bitValid <= took;
      bitOut <= dlBit;
      // three slots per frame unless fast: a burst of three, then a random gap.
      if (!rst_n || gap > 0)
      begin
         gap = rst_n ? gap - 1 : 0;
         dlSlot <= #1 1'b0;
      end
      else if (fast || pos < 3)
      begin
         pos++;
         dlSlot <= #1 1'b1;
      end
      else
      begin
         pos = 0;
         gap = 1 + $urandom % 8;
         dlSlot <= #1 1'b0;
      end
   end
endmodule

// ===== verification/ds3_pmdl_lapd_transmitter_tb.sv
// Self-checking bench: builds expected frames bit by bit and compares them
// with the serial stream captured by the framer model.
module ds3_pmdl_lapd_transmitter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RETX = 2000;
   logic mclk = 0, rst_n = 0, busWr = 0, busRd = 0, fast = 0;
   logic [7:0] busAddr = 8'h00, busWrData = 8'h00, d;
   wire [7:0] busRdData;
   wire dlSlot, dlBit, doneIrq, bitValid, bitOut;
   logic q[$], want[$];
   logic [7:0] pay[$];
   logic [15:0] crc;
   int ones, c, miscompares = 0, totalChecks = 0;
   always #10 mclk = ~mclk;
   ds3_pmdl_lapd_transmitter #(.RETX_CYCLES(26'h7d0)) dut_u (.mclk(mclk), .rst_n(rst_n), .busAddr(busAddr),
      .busWrData(busWrData), .busWr(busWr), .busRd(busRd), .busRdData(busRdData), .dlSlot(dlSlot),
      .dlBit(dlBit), .doneIrq(doneIrq));
   dl_framer_model fm_u (.mclk(mclk), .rst_n(rst_n), .fast(fast), .dlSlot(dlSlot), .dlBit(dlBit),
      .bitValid(bitValid), .bitOut(bitOut));
   always @(posedge mclk)
      if (bitValid)
         q.push_back(bitOut);
   task completeRun;
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      #1 busWr = 1;
      busAddr = a;
      busWrData = v;
      @(posedge mclk);
      #1 busWr = 0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      #1 busRd = 1;
      busAddr = a;
      @(posedge mclk);
      #1 busRd = 0;
      v = busRdData;
   endtask
   task ldMsg(input int n);
      logic [7:0] b;
      pay.delete();
      for (int k = 0; k < n; k++)
      begin
         b = k == 0 ? (n == 76 ? 8'h38 : 8'h3f) : (k % 6 == 1 ? 8'hff : 8'($urandom));
         pay.push_back(b);
         wr(8'h86 + 8'(k), b);
      end
   endtask
   // Octets go out low bit first; a zero follows five payload ones.
   task putOct(input logic [7:0] o, input bit inCrc, input bit stuff);
      for (int b = 0; b < 8; b++)
      begin
         want.push_back(o[b]);
         if (inCrc)
            crc = (crc >> 1) ^ ((crc[0] ^ o[b]) ? 16'h8408 : 16'h0000);
         ones = o[b] ? ones + 1 : 0;
         if (stuff && ones == 5)
         begin
            want.push_back(1'b0);
            ones = 0;
         end
      end
   endtask
   function automatic logic [7:0] octAt(input int i);
      for (int b = 0; b < 8; b++)
         octAt[b] = q[i + b];
   endfunction
   task checkFrame;
      logic [15:0] f;
      int n;
      want.delete();
      crc = 16'hffff;
      putOct(8'h7e, 1, 0);
      putOct(8'h3c, 1, 0);
      putOct(8'h01, 1, 0);
      putOct(8'h03, 1, 0);
      ones = 0;
      foreach (pay[k])
         putOct(pay[k], 1, 1);
      f = ~crc;
      putOct(f[15:8], 0, 0);
      putOct(f[7:0], 0, 0);
      putOct(8'h7e, 0, 0);
      // Ones captured before enabling took effect are not part of the stream.
      while (q.size() > 0 && q[0] === 1'b1)
         void'(q.pop_front());
      while (q.size() >= 16 && octAt(8) === 8'h7e)
         repeat (8) void'(q.pop_front());
      n = 0;
      for (int i = 0; i < want.size(); i++)
         if (i >= q.size() || q[i] !== want[i])
            n++;
      chk(16'(n), 16'h0000);
      repeat (want.size())
         if (q.size() > 0)
            void'(q.pop_front());
   endtask
   task waitDone;
      c = 0;
      while (doneIrq !== 1'b1 && c < 20000)
      begin
         @(posedge mclk);
         c++;
      end
      #1 chk(16'(doneIrq), 16'h0001);
      repeat (4) @(posedge mclk);
   endtask
   initial
   begin
      #1_000_000;
      miscompares++;
      $display("watchdog expired at %0t", $time);
      completeRun;
   end
   initial
   begin
      void'($urandom(32'ha5f33054));
      repeat (16) @(posedge mclk);
      #1 rst_n = 1;
      rd(8'h33, d);
      chk(16'(d), 16'h0000);
      rd(8'h34, d);
      chk(16'(d), 16'h0000);
      rd(8'hde, d);
      chk(16'(d), 16'h0000);
      $display("test reset done");
      ldMsg(76);
      q.delete();
      wr(8'h33, 8'h01);
      wr(8'h34, 8'h02);
      wr(8'h34, 8'h0a);
      rd(8'h34, d);
      chk(16'(d), 16'h000e);
      waitDone;
      checkFrame;
      rd(8'h34, d);
      chk(16'(d), 16'h000b);
      rd(8'h34, d);
      chk(16'(d), 16'h000a);
      chk(16'(doneIrq), 16'h0000);
      $display("test short frame done");
      waitDone;
      chk(16'(c > RETX), 16'h0001);
      checkFrame;
      rd(8'h34, d);
      $display("test repeat done");
      wr(8'h33, 8'h00);
      repeat (3) @(posedge mclk);
      #1 fast = 1;
      chk(16'(dlBit), 16'h0001);
      ldMsg(82);
      q.delete();
      wr(8'h33, 8'hff);
      rd(8'h33, d);
      chk(16'(d), 16'h000b);
      wr(8'h34, 8'h00);
      wr(8'h34, 8'h08);
      c = 0;
      do
         rd(8'h34, d);
      while (d[2] !== 1'b0 && c++ < 5000);
      chk(16'(d & 8'hfe), 16'h0008);
      chk(16'(doneIrq), 16'h0000);
      repeat (4) @(posedge mclk);
      checkFrame;
      $display("test long frame done");
      wr(8'h34, 8'h00);
      wr(8'h34, 8'h08);
      repeat (100) @(posedge mclk);
      wr(8'h33, 8'h00);
      rd(8'h34, d);
      chk(16'(d[2]), 16'h0000);
      chk(16'(dlBit), 16'h0001);
      rst_n = 0;
      repeat (3) @(posedge mclk);
      #1 rst_n = 1;
      rd(8'h33, d);
      chk(16'(d), 16'h0000);
      $display("test abort done");
      completeRun;
   end
endmodule
